// [xfer_ops_params.svh]
// Constants for the control and transfer operation executor
`ifndef XFER_OPS_PARAMS_SVH
`define XFER_OPS_PARAMS_SVH

// ==========================================================
// Operation codes presented by the fetch stage
`define OPC_NOP        4'h0
`define OPC_LOAD_PM    4'h1
`define OPC_STORE_PM   4'h2
`define OPC_PUSH       4'h3
`define OPC_POP        4'h4
`define OPC_IN         4'h5
`define OPC_OUT        4'h6
`define OPC_SLEEP      4'h7
`define OPC_WDOG       4'h8
`define OPC_BREAK      4'h9

// ==========================================================
// Cycle counts of the timed operations
`define LOAD_PM_CYCLES 3
`define PUSH_CYCLES    2
`define POP_CYCLES     2
`define SINGLE_CYCLES  1

// ==========================================================
// Field widths and reset values
`define REG_IDX_W      5
`define IO_ADDR_W      6
`define ADDR_W         16
`define PTR_STEP       16'h0001
`define BYTE_RST       8'h00
`define WORD_RST       16'h0000
`define IDX_RST        5'h00
`define IO_RST         6'h00

`endif

// [xfer_ops_pkg.sv]
// Types shared by the control and transfer operation executor
package xfer_ops_pkg;
  `include "xfer_ops_params.svh"

  // ==========================================================
  // Operation codes
  typedef enum logic [3:0] {
    OP_NOP      = `OPC_NOP,
    OP_LOAD_PM  = `OPC_LOAD_PM,
    OP_STORE_PM = `OPC_STORE_PM,
    OP_PUSH     = `OPC_PUSH,
    OP_POP      = `OPC_POP,
    OP_IN       = `OPC_IN,
    OP_OUT      = `OPC_OUT,
    OP_SLEEP    = `OPC_SLEEP,
    OP_WDOG     = `OPC_WDOG,
    OP_BREAK    = `OPC_BREAK
  } op_code_t;

  // ==========================================================
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE     = 6'h01,
    ST_LOAD_RD  = 6'h02,
    ST_LOAD_WB  = 6'h04,
    ST_PUSH_END = 6'h08,
    ST_POP_WB   = 6'h10,
    ST_STORE_WT = 6'h20
  } state_t;
endpackage : xfer_ops_pkg

// [op_decode_if.sv]
// Carrier between the executor and its operation decoder
`timescale 1ns/1ps
interface op_decode_if;
  logic [3:0] code;      // Raw operation code
  logic       load_pm;   // Program byte load with post-increment
  logic       store_pm;  // Program word store
  logic       push;      // Stack save
  logic       pop;       // Stack restore
  logic       io_in;     // Port input
  logic       io_out;    // Port output
  logic       sleep;     // Sleep request
  logic       wdog;      // Watchdog restart
  logic       brk;       // Debug break
  modport dec (input code, output load_pm, store_pm, push, pop, io_in, io_out, sleep, wdog, brk);
  modport exe (output code, input load_pm, store_pm, push, pop, io_in, io_out, sleep, wdog, brk);
endinterface : op_decode_if

// [op_decode.sv]
// Operation decoder: raw code to one strobe per operation class
`timescale 1ns/1ps
module op_decode (
  op_decode_if.dec dec_if
);
  // ==========================================================
  // Decode
  // Unknown codes decode to no strobe, so they behave as a no-operation
  always_comb begin
    dec_if.load_pm  = 1'b0;
    dec_if.store_pm = 1'b0;
    dec_if.push     = 1'b0;
    dec_if.pop      = 1'b0;
    dec_if.io_in    = 1'b0;
    dec_if.io_out   = 1'b0;
    dec_if.sleep    = 1'b0;
    dec_if.wdog     = 1'b0;
    dec_if.brk      = 1'b0;
    case (dec_if.code)
      xfer_ops_pkg::OP_LOAD_PM:  dec_if.load_pm  = 1'b1;
      xfer_ops_pkg::OP_STORE_PM: dec_if.store_pm = 1'b1;
      xfer_ops_pkg::OP_PUSH:     dec_if.push     = 1'b1;
      xfer_ops_pkg::OP_POP:      dec_if.pop      = 1'b1;
      xfer_ops_pkg::OP_IN:       dec_if.io_in    = 1'b1;
      xfer_ops_pkg::OP_OUT:      dec_if.io_out   = 1'b1;
      xfer_ops_pkg::OP_SLEEP:    dec_if.sleep    = 1'b1;
      xfer_ops_pkg::OP_WDOG:     dec_if.wdog     = 1'b1;
      xfer_ops_pkg::OP_BREAK:    dec_if.brk      = 1'b1;
      default:                   dec_if.brk      = 1'b0;
    endcase
  end
endmodule : op_decode

// [xfer_ops_exec.sv]
// Executor for program memory, stack, port and core control operations
`timescale 1ns/1ps
`include "xfer_ops_params.svh"

// Summary of operation
// (RL1) Load pointer byte, bump pointer, three cycles
// (RL2) Store low register pair word at pointer
// (RL3) Save source register on stack, two cycles
// (RL4) Restore stack top into register, two cycles
// (RL5) Sleep: one cycle, request power saving
// (RL6) Watchdog restart: one cycle, pulse timer
// (RL7) Break acts only when debug system present
// (RL8) Port in/out: one byte, one cycle
module xfer_ops_exec (
  input  wire logic        core_clk_in,          // Core clock, 200 MHz
  input  wire logic        rst_in,               // Synchronous reset, active high
  input  wire logic        op_valid_in,          // Operation offered
  input  wire logic [3:0]  op_code_in,           // Operation code
  input  wire logic [4:0]  op_reg_in,            // Destination or source register index
  input  wire logic [5:0]  op_io_addr_in,        // Port address for in/out
  input  wire logic [7:0]  source_register_in,   // Value of the source register
  input  wire logic [15:0] pointer_in,           // High pointer pair value
  input  wire logic [15:0] low_register_pair_in, // Low register pair value
  input  wire logic [15:0] stack_ptr_in,         // Stack pointer value
  input  wire logic [15:0] pm_rd_data_in,        // Program word, one cycle after read
  input  wire logic        pm_wr_done_in,        // Program store finished
  input  wire logic [7:0]  dm_rd_data_in,        // Data memory byte, same cycle as read
  input  wire logic [7:0]  io_rd_data_in,        // Port byte at op_io_addr_in, same cycle
  input  wire logic        debug_present_in,     // On-chip debug system active
  output logic             op_ready_out,         // Executor can take an operation
  output logic             rf_wr_en_out,         // Register write strobe
  output logic [4:0]       rf_wr_idx_out,        // Register write index
  output logic [7:0]       rf_wr_data_out,       // Register write data
  output logic             ptr_wr_en_out,        // Pointer write strobe
  output logic [15:0]      ptr_wr_data_out,      // New pointer value
  output logic             sp_wr_en_out,         // Stack pointer write strobe
  output logic [15:0]      sp_wr_data_out,       // New stack pointer value
  output logic             pm_rd_en_out,         // Program memory read strobe
  output logic             pm_wr_en_out,         // Program memory write strobe
  output logic [15:0]      pm_addr_out,          // Program word address
  output logic [15:0]      pm_wr_data_out,       // Program word to store
  output logic             dm_rd_en_out,         // Data memory read strobe
  output logic             dm_wr_en_out,         // Data memory write strobe
  output logic [15:0]      dm_addr_out,          // Data memory address
  output logic [7:0]       dm_wr_data_out,       // Data memory write byte
  output logic             io_wr_en_out,         // Port write strobe
  output logic [5:0]       io_addr_out,          // Port write address
  output logic [7:0]       io_wr_data_out,       // Port write byte
  output logic             sleep_req_out,        // Pulse to sleep control
  output logic             wdt_restart_out,      // Pulse to watchdog timer
  output logic             debug_break_out,      // Pulse to debug system
  output logic             flags_wr_en_out       // Status flag write, never raised
);

  // ==========================================================
  // Decoder
  op_decode_if dec_if ();                         // Decoded operation strobes
  op_decode    u_dec (.dec_if(dec_if));

  assign dec_if.code = op_code_in;

  // ==========================================================
  // Local state
  xfer_ops_pkg::state_t state_r;                  // Sequencer state
  xfer_ops_pkg::state_t state_nxt;                // Next sequencer state
  logic                 take;                     // Operation accepted this edge
  logic [4:0]           dest_r;                   // Latched destination index
  logic                 byte_hi_r;                // Odd pointer picks high byte
  logic [15:0]          ptr_next;                 // Pointer plus one
  logic [15:0]          sp_up;                    // Stack pointer plus one

  assign take     = op_valid_in && op_ready_out;
  assign ptr_next = pointer_in + `PTR_STEP;
  assign sp_up    = stack_ptr_in + `PTR_STEP;

  // ==========================================================
  // Next state
  // Only the multi-cycle operations leave idle; the rest finish at acceptance
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      xfer_ops_pkg::ST_IDLE: begin
        if (take && dec_if.load_pm) begin
          state_nxt = xfer_ops_pkg::ST_LOAD_RD;  // RL1
        end else if (take && dec_if.store_pm) begin
          state_nxt = xfer_ops_pkg::ST_STORE_WT; // RL2
        end else if (take && dec_if.push) begin
          state_nxt = xfer_ops_pkg::ST_PUSH_END; // RL3
        end else if (take && dec_if.pop) begin
          state_nxt = xfer_ops_pkg::ST_POP_WB;   // RL4
        end
      end
      xfer_ops_pkg::ST_LOAD_RD:  state_nxt = xfer_ops_pkg::ST_LOAD_WB;
      xfer_ops_pkg::ST_LOAD_WB:  state_nxt = xfer_ops_pkg::ST_IDLE;
      xfer_ops_pkg::ST_PUSH_END: state_nxt = xfer_ops_pkg::ST_IDLE;
      xfer_ops_pkg::ST_POP_WB:   state_nxt = xfer_ops_pkg::ST_IDLE;
      xfer_ops_pkg::ST_STORE_WT: begin
        // The store has no fixed length; memory says when it is done
        if (pm_wr_done_in) begin
          state_nxt = xfer_ops_pkg::ST_IDLE;     // RL2
        end
      end
      default: state_nxt = xfer_ops_pkg::ST_IDLE;
    endcase
  end

  // ==========================================================
  // State register and ready
  // Ready is registered from the next state, so it drops right after a take of a load, store, save or restore
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r      <= xfer_ops_pkg::ST_IDLE;
      op_ready_out <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      op_ready_out <= (state_nxt == xfer_ops_pkg::ST_IDLE);
    end
  end

  // ==========================================================
  // Latched operands for the later cycles of a load or restore
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dest_r    <= `IDX_RST;
      byte_hi_r <= 1'b0;
    end else if (take) begin
      dest_r    <= op_reg_in;
      byte_hi_r <= pointer_in[0];
    end
  end

  // ==========================================================
  // Register file and pointer writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rf_wr_en_out    <= 1'b0;
      rf_wr_idx_out   <= `IDX_RST;
      rf_wr_data_out  <= `BYTE_RST;
      ptr_wr_en_out   <= 1'b0;
      ptr_wr_data_out <= `WORD_RST;
    end else begin
      rf_wr_en_out  <= 1'b0;
      ptr_wr_en_out <= 1'b0;
      if (take && dec_if.io_in) begin
        // Port byte is taken in the accepting cycle itself
        rf_wr_en_out   <= 1'b1;                  // RL8
        rf_wr_idx_out  <= op_reg_in;
        rf_wr_data_out <= io_rd_data_in;         // RL8
      end else if (take && dec_if.load_pm) begin
        // Pointer moves at once; the read already holds the old address
        ptr_wr_en_out   <= 1'b1;                 // RL1
        ptr_wr_data_out <= ptr_next;             // RL1
      end else if (state_r == xfer_ops_pkg::ST_LOAD_WB) begin
        rf_wr_en_out   <= 1'b1;                  // RL1
        rf_wr_idx_out  <= dest_r;
        rf_wr_data_out <= byte_hi_r ? pm_rd_data_in[15:8] : pm_rd_data_in[7:0]; // RL1
      end else if (state_r == xfer_ops_pkg::ST_POP_WB) begin
        rf_wr_en_out   <= 1'b1;                  // RL4
        rf_wr_idx_out  <= dest_r;
        rf_wr_data_out <= dm_rd_data_in;         // RL4
      end
    end
  end

  // ==========================================================
  // Program memory access
  // Byte pointer over word memory: word address is the pointer halved
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pm_rd_en_out   <= 1'b0;
      pm_wr_en_out   <= 1'b0;
      pm_addr_out    <= `WORD_RST;
      pm_wr_data_out <= `WORD_RST;
    end else begin
      pm_rd_en_out <= 1'b0;
      pm_wr_en_out <= 1'b0;
      if (take && dec_if.load_pm) begin
        pm_rd_en_out <= 1'b1;                    // RL1
        pm_addr_out  <= {1'b0, pointer_in[15:1]};
      end else if (take && dec_if.store_pm) begin
        pm_wr_en_out   <= 1'b1;                  // RL2
        pm_addr_out    <= {1'b0, pointer_in[15:1]};
        pm_wr_data_out <= low_register_pair_in;  // RL2
      end
    end
  end

  // ==========================================================
  // Stack through data memory
  // Save writes at the pointer then moves down; restore moves up then reads
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dm_rd_en_out   <= 1'b0;
      dm_wr_en_out   <= 1'b0;
      dm_addr_out    <= `WORD_RST;
      dm_wr_data_out <= `BYTE_RST;
      sp_wr_en_out   <= 1'b0;
      sp_wr_data_out <= `WORD_RST;
    end else begin
      dm_rd_en_out <= 1'b0;
      dm_wr_en_out <= 1'b0;
      sp_wr_en_out <= 1'b0;
      if (take && dec_if.push) begin
        dm_wr_en_out   <= 1'b1;                  // RL3
        dm_addr_out    <= stack_ptr_in;
        dm_wr_data_out <= source_register_in;    // RL3
        sp_wr_en_out   <= 1'b1;
        sp_wr_data_out <= stack_ptr_in - `PTR_STEP;
      end else if (take && dec_if.pop) begin
        dm_rd_en_out   <= 1'b1;                  // RL4
        dm_addr_out    <= sp_up;
        sp_wr_en_out   <= 1'b1;
        sp_wr_data_out <= sp_up;                 // RL4
      end
    end
  end

  // ==========================================================
  // Port writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      io_wr_en_out   <= 1'b0;
      io_addr_out    <= `IO_RST;
      io_wr_data_out <= `BYTE_RST;
    end else begin
      io_wr_en_out <= 1'b0;
      if (take && dec_if.io_out) begin
        io_wr_en_out   <= 1'b1;                  // RL8
        io_addr_out    <= op_io_addr_in;
        io_wr_data_out <= source_register_in;    // RL8
      end
    end
  end

  // ==========================================================
  // Core control pulses
  // Break without a debug system is dropped, so it runs as a no-operation
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sleep_req_out   <= 1'b0;
      wdt_restart_out <= 1'b0;
      debug_break_out <= 1'b0;
    end else begin
      sleep_req_out   <= take && dec_if.sleep;                     // RL5
      wdt_restart_out <= take && dec_if.wdog;                      // RL6
      debug_break_out <= take && dec_if.brk && debug_present_in;   // RL7
    end
  end

  // ==========================================================
  // Status flags
  // None of these operations touch the flags, so the strobe stays low
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      flags_wr_en_out <= 1'b0;
    end else begin
      flags_wr_en_out <= 1'b0;                   // RL1 RL2 RL3 RL4 RL5 RL6 RL7 RL8
    end
  end

endmodule : xfer_ops_exec

// [xfer_ops_checker.sv]
// Assertion checker for the control and transfer operation executor
`timescale 1ns/1ps
module xfer_ops_checker (
  input wire logic        core_clk_in, rst_in, op_valid_in, op_ready_out, debug_present_in,
  input wire logic [3:0]  op_code_in,
  input wire logic [4:0]  op_reg_in, rf_wr_idx_out,
  input wire logic [7:0]  source_register_in, io_rd_data_in, rf_wr_data_out, io_wr_data_out,
  input wire logic [15:0] pointer_in, low_register_pair_in, stack_ptr_in, dm_addr_out,
  input wire logic [15:0] ptr_wr_data_out, sp_wr_data_out, pm_addr_out, pm_wr_data_out,
  input wire logic        rf_wr_en_out, ptr_wr_en_out, sp_wr_en_out, pm_rd_en_out,
  input wire logic        pm_wr_en_out, dm_rd_en_out, dm_wr_en_out, io_wr_en_out,
  input wire logic        sleep_req_out, wdt_restart_out, debug_break_out, flags_wr_en_out
);
  // ==========================================================
  // Common clocking; nothing is judged while reset is applied
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // An operation of class c is taken at this edge
  sequence take_s(logic [3:0] c);
    op_valid_in && op_ready_out && op_code_in == c;
  endsequence
  // Executor blocked for one cycle, then free again
  sequence gap_s;
    !op_ready_out ##1 op_ready_out;
  endsequence

  // ==========================================================
  // Timed operations
  chk_load_fetch_step: assert property (take_s(xfer_ops_pkg::OP_LOAD_PM) |=>
    pm_rd_en_out && ptr_wr_en_out && pm_addr_out == ($past(pointer_in) >> 1)
    && ptr_wr_data_out == $past(pointer_in) + 16'h0001) else $error("load fetch wrong");
  chk_load_three_cycles: assert property (take_s(xfer_ops_pkg::OP_LOAD_PM) |=>
    !op_ready_out ##1 !op_ready_out ##1 (op_ready_out && rf_wr_en_out
    && rf_wr_idx_out == $past(op_reg_in, 3))) else $error("load timing wrong");
  chk_store_word_out: assert property (take_s(xfer_ops_pkg::OP_STORE_PM) |=>
    pm_wr_en_out && !op_ready_out && pm_wr_data_out == $past(low_register_pair_in)
    && pm_addr_out == ($past(pointer_in) >> 1)) else $error("store word wrong");
  chk_push_two_cycles: assert property (take_s(xfer_ops_pkg::OP_PUSH) |=>
    (dm_wr_en_out && sp_wr_en_out && dm_addr_out == $past(stack_ptr_in)) ##0 gap_s)
    else $error("push frame wrong");
  chk_pop_two_cycles: assert property (take_s(xfer_ops_pkg::OP_POP) |=>
    (dm_rd_en_out && dm_addr_out == $past(stack_ptr_in) + 16'h0001) ##0 gap_s
    ##0 rf_wr_en_out) else $error("pop frame wrong");
  // Port operations finish in the cycle after the take
  chk_port_in_byte: assert property (take_s(xfer_ops_pkg::OP_IN) |=>
    rf_wr_en_out && op_ready_out && rf_wr_idx_out == $past(op_reg_in)
    && rf_wr_data_out == $past(io_rd_data_in)) else $error("port input wrong");
  chk_port_out_byte: assert property (take_s(xfer_ops_pkg::OP_OUT) |=>
    io_wr_en_out && op_ready_out && io_wr_data_out == $past(source_register_in))
    else $error("port output wrong");
  // ==========================================================
  // Control pulses: one per taken operation, break only with a debug system; flags never written
  chk_sleep_one_pulse: assert property (sleep_req_out ==
    $past(op_valid_in && op_ready_out && op_code_in == xfer_ops_pkg::OP_SLEEP))
    else $error("sleep pulse wrong");
  chk_wdt_one_pulse: assert property (wdt_restart_out ==
    $past(op_valid_in && op_ready_out && op_code_in == xfer_ops_pkg::OP_WDOG))
    else $error("watchdog pulse wrong");
  chk_break_debug_gate: assert property (debug_break_out == $past(op_valid_in
    && op_ready_out && op_code_in == xfer_ops_pkg::OP_BREAK && debug_present_in))
    else $error("break pulse wrong");
  chk_flags_never_written: assert property (!flags_wr_en_out)
    else $error("status flags written");
endmodule : xfer_ops_checker

// [mcu_control_and_transfer_ops_tb.sv]
// Self-checking testbench for the control and transfer operation executor
`timescale 1ns/1ps
module mcu_control_and_transfer_ops_tb;
  // ==========================================================
  // Design stimulus and observed outputs
  logic        core_clk_in, rst_in, op_valid_in, pm_wr_done_in, debug_present_in;
  logic [3:0]  op_code_in;
  logic [4:0]  op_reg_in, rf_wr_idx_out;
  logic [5:0]  op_io_addr_in, io_addr_out;
  logic [7:0]  source_register_in, dm_rd_data_in, io_rd_data_in;
  logic [7:0]  rf_wr_data_out, dm_wr_data_out, io_wr_data_out;
  logic [15:0] pointer_in, low_register_pair_in, stack_ptr_in, pm_rd_data_in;
  logic [15:0] ptr_wr_data_out, sp_wr_data_out, pm_addr_out, pm_wr_data_out, dm_addr_out;
  logic        op_ready_out, rf_wr_en_out, ptr_wr_en_out, sp_wr_en_out, pm_rd_en_out;
  logic        pm_wr_en_out, dm_rd_en_out, dm_wr_en_out, io_wr_en_out, sleep_req_out;
  logic        wdt_restart_out, debug_break_out, flags_wr_en_out;
  int          error_cnt = 0;  // Mismatches seen
  int          n_tests   = 0;  // Comparisons made

  xfer_ops_exec xfer_ops_exec_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
    .op_valid_in(op_valid_in), .op_code_in(op_code_in), .op_reg_in(op_reg_in),
    .op_io_addr_in(op_io_addr_in), .source_register_in(source_register_in),
    .pointer_in(pointer_in), .low_register_pair_in(low_register_pair_in),
    .stack_ptr_in(stack_ptr_in), .pm_rd_data_in(pm_rd_data_in), .pm_wr_done_in(pm_wr_done_in),
    .dm_rd_data_in(dm_rd_data_in), .io_rd_data_in(io_rd_data_in),
    .debug_present_in(debug_present_in), .op_ready_out(op_ready_out),
    .rf_wr_en_out(rf_wr_en_out), .rf_wr_idx_out(rf_wr_idx_out), .rf_wr_data_out(rf_wr_data_out),
    .ptr_wr_en_out(ptr_wr_en_out), .ptr_wr_data_out(ptr_wr_data_out),
    .sp_wr_en_out(sp_wr_en_out), .sp_wr_data_out(sp_wr_data_out), .pm_rd_en_out(pm_rd_en_out),
    .pm_wr_en_out(pm_wr_en_out), .pm_addr_out(pm_addr_out), .pm_wr_data_out(pm_wr_data_out),
    .dm_rd_en_out(dm_rd_en_out), .dm_wr_en_out(dm_wr_en_out), .dm_addr_out(dm_addr_out),
    .dm_wr_data_out(dm_wr_data_out), .io_wr_en_out(io_wr_en_out), .io_addr_out(io_addr_out),
    .io_wr_data_out(io_wr_data_out), .sleep_req_out(sleep_req_out),
    .wdt_restart_out(wdt_restart_out), .debug_break_out(debug_break_out),
    .flags_wr_en_out(flags_wr_en_out));

  // 200 MHz core clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end

  // ==========================================================
  // Comparison, expectation and closing helpers
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Byte picked out of a program word: odd pointer takes the high half
  function automatic logic [7:0] pm_byte(input logic [15:0] w, input logic [15:0] z);
    return z[0] ? w[15:8] : w[7:0];
  endfunction : pm_byte

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // One operation: offer it at a falling edge, then check each cycle after the take except the second of a store
  task automatic run(input logic [3:0] c, input logic [15:0] z, input logic [15:0] s);
    check("ready before take", {15'h0000, op_ready_out}, 16'h0001);
    op_code_in = c;
    op_reg_in = 5'($urandom);
    op_io_addr_in = 6'($urandom);
    source_register_in = 8'($urandom);
    low_register_pair_in = 16'($urandom);
    io_rd_data_in = 8'($urandom);
    debug_present_in = 1'($urandom);
    pointer_in = z;
    stack_ptr_in = s;
    op_valid_in = 1'b1;
    @(negedge core_clk_in);
    // Valid stays up: refused while busy, and the next call reuses it without a glitch
    pm_rd_data_in = 16'($urandom);
    dm_rd_data_in = 8'($urandom);
    check("flags", {15'h0000, flags_wr_en_out}, 16'h0000);
    case (c)
      xfer_ops_pkg::OP_LOAD_PM: begin
        check("pm addr", pm_addr_out, z >> 1);
        check("ptr next", ptr_wr_data_out, z + 16'h0001);
        check("pm read", {14'h0000, pm_rd_en_out, ptr_wr_en_out}, 16'h0003);
        @(negedge core_clk_in);
        check("load busy", {15'h0000, op_ready_out}, 16'h0000);
        @(negedge core_clk_in);
        check("load wb", {10'h000, rf_wr_en_out, rf_wr_idx_out}, {11'h001, op_reg_in});
        check("load byte", {8'h00, rf_wr_data_out}, {8'h00, pm_byte(pm_rd_data_in, z)});
      end
      xfer_ops_pkg::OP_STORE_PM: begin
        check("pm word", pm_wr_data_out, low_register_pair_in);
        check("pm write", {15'h0000, pm_wr_en_out}, 16'h0001);
        check("pm store addr", pm_addr_out, z >> 1);
        repeat (2) @(negedge core_clk_in);
        check("store waits", {15'h0000, op_ready_out}, 16'h0000);
        pm_wr_done_in = 1'b1;
        @(negedge core_clk_in);
        pm_wr_done_in = 1'b0;
      end
      xfer_ops_pkg::OP_PUSH: begin
        check("push addr", dm_addr_out, s);
        check("push data", {8'h00, dm_wr_data_out}, {8'h00, source_register_in});
        check("push sp", sp_wr_data_out, s - 16'h0001);
        check("push busy", {15'h0000, op_ready_out}, 16'h0000);
        check("push strobes", {14'h0000, dm_wr_en_out, sp_wr_en_out}, 16'h0003);
        @(negedge core_clk_in);
      end
      xfer_ops_pkg::OP_POP: begin
        check("pop addr", dm_addr_out, s + 16'h0001);
        check("pop sp", sp_wr_data_out, s + 16'h0001);
        check("pop strobes", {14'h0000, dm_rd_en_out, sp_wr_en_out}, 16'h0003);
        @(negedge core_clk_in);
        check("pop byte", {8'h00, rf_wr_data_out}, {8'h00, dm_rd_data_in});
        check("pop idx", {10'h000, rf_wr_en_out, rf_wr_idx_out}, {11'h001, op_reg_in});
      end
      xfer_ops_pkg::OP_IN: begin
        check("in byte", {8'h00, rf_wr_data_out}, {8'h00, io_rd_data_in});
        check("in wb", {10'h000, rf_wr_en_out, rf_wr_idx_out}, {11'h001, op_reg_in});
      end
      xfer_ops_pkg::OP_OUT:
        check("out", {io_wr_en_out, io_addr_out, io_wr_data_out},
          {1'b1, op_io_addr_in, source_register_in});
      xfer_ops_pkg::OP_SLEEP: check("sleep", {15'h0000, sleep_req_out}, 16'h0001);
      xfer_ops_pkg::OP_WDOG: check("watchdog", {15'h0000, wdt_restart_out}, 16'h0001);
      xfer_ops_pkg::OP_BREAK:
        check("break", {15'h0000, debug_break_out}, {15'h0000, debug_present_in});
      default: check("nop", {14'h0000, rf_wr_en_out, io_wr_en_out}, 16'h0000);
    endcase
    check("ready after", {15'h0000, op_ready_out}, 16'h0001);
    $display("test op %h done", c);
  endtask : run

  // ==========================================================
  // Main sequence: reset, corner cases, then random operations
  initial begin
    {op_valid_in, pm_wr_done_in, debug_present_in, op_code_in, op_reg_in} = '0;
    {op_io_addr_in, source_register_in, dm_rd_data_in, io_rd_data_in} = '0;
    {pointer_in, low_register_pair_in, stack_ptr_in, pm_rd_data_in} = '0;
    rst_in = 1'b1;
    void'($urandom(32'hBF84AA18));
    repeat (3) @(posedge core_clk_in);
    @(negedge core_clk_in);
    rst_in = 1'b0;
    check("ready in reset", {15'h0000, op_ready_out}, 16'h0000);
    @(negedge core_clk_in);
    // Pointer and stack wrap-around, odd and even bytes, an undefined code
    run(xfer_ops_pkg::OP_LOAD_PM, 16'hFFFF, 16'h0000);
    run(xfer_ops_pkg::OP_LOAD_PM, 16'h0000, 16'h0000);
    run(xfer_ops_pkg::OP_PUSH, 16'h0000, 16'h0000);
    run(xfer_ops_pkg::OP_POP, 16'h0000, 16'hFFFF);
    run(4'hF, 16'h0000, 16'h0000);
    for (int i = 0; i < 60; i++) begin
      run(4'($urandom_range(9, 0)), 16'($urandom), 16'($urandom));
    end
    give_verdict();
  end

  // Cut a hang short
  initial begin
    repeat (5000) @(posedge core_clk_in);
    error_cnt++;
    give_verdict();
  end
endmodule : mcu_control_and_transfer_ops_tb

bind xfer_ops_exec xfer_ops_checker xfer_ops_checker_i (.core_clk_in(core_clk_in),
  .rst_in(rst_in), .op_valid_in(op_valid_in), .op_ready_out(op_ready_out),
  .debug_present_in(debug_present_in), .op_code_in(op_code_in), .op_reg_in(op_reg_in),
  .rf_wr_idx_out(rf_wr_idx_out), .source_register_in(source_register_in),
  .io_rd_data_in(io_rd_data_in), .rf_wr_data_out(rf_wr_data_out),
  .io_wr_data_out(io_wr_data_out), .pointer_in(pointer_in),
  .low_register_pair_in(low_register_pair_in), .stack_ptr_in(stack_ptr_in),
  .dm_addr_out(dm_addr_out), .ptr_wr_data_out(ptr_wr_data_out),
  .sp_wr_data_out(sp_wr_data_out), .pm_addr_out(pm_addr_out), .pm_wr_data_out(pm_wr_data_out),
  .rf_wr_en_out(rf_wr_en_out), .ptr_wr_en_out(ptr_wr_en_out), .sp_wr_en_out(sp_wr_en_out),
  .pm_rd_en_out(pm_rd_en_out), .pm_wr_en_out(pm_wr_en_out), .dm_rd_en_out(dm_rd_en_out),
  .dm_wr_en_out(dm_wr_en_out), .io_wr_en_out(io_wr_en_out), .sleep_req_out(sleep_req_out),
  .wdt_restart_out(wdt_restart_out), .debug_break_out(debug_break_out),
  .flags_wr_en_out(flags_wr_en_out));
